// ==== rtl/gsw_status.sv ====
// gateway status word keeper with axi4-lite registers
`include "gsw_cfg.svh"
`default_nettype none
// Functional notes
// RULE_01: on an error the gateway halts and the stop digit (bits 8-11) reads zero.
// RULE_02: a fatal error puts 8 in the top digit so bit 15 is one.
// RULE_03: without error the low two digits give, in bcd 00-31, the last serviced unit.
// RULE_04: after power-up the low digits read 00 until some unit has been serviced.
// RULE_05: low digits read 00 when the unit count is zero, run is zero or the unit is absent.
// RULE_06: without error the run digit is 1 while running and 0 while stopped.
// RULE_07: without fatal error the top digit is 0 so bit 15 is zero.
// RULE_08: memory locked in run mode, link failure or program protect make faults unreportable.
// RULE_09: an unreportable condition stops all traffic and lights the error indicator.
// RULE_10: in the error layout the low digits hold 01 watchdog, 02 syntax or 15 allocation.
// RULE_11: the cpu sets the unit count; a count of zero means no unit is polled.
// RULE_12: the whole 16-bit status word is written to host memory in one update.
module gsw_status (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // gateway core events
    input wire gsw_pkg::gsw_fault_t fault_in,
    input wire gsw_pkg::gsw_svc_t svc_in,
    // cpu link condition pins
    input wire gsw_pkg::gsw_block_t block_pin,
    // host memory status update
    output logic [15:0] host_word_memory_data,
    output logic host_word_memory_write,
    // gateway control and indicators
    output logic comm_enable,
    output logic err_led,
    output logic irq
);
    import gsw_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    gsw_block_t block_meta;
    gsw_block_t block_sync;

    // two flops before any logic reads the pins
    always_ff @(posedge core_clk) begin
        if (reset) begin
            block_meta <= '0;
            block_sync <= '0;
        end else begin
            block_meta <= block_pin;
            block_sync <= block_meta;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [15:0] status;
    logic [7:0] fault_code;
    logic fatal;
    logic unreportable;
    logic [7:0] last_unit;
    gsw_mode_t mode;
    gsw_mode_t next_mode;
    logic [15:0] next_status;
    logic run_set;
    logic cnt_zero;
    logic any_fault;
    logic blocked;
    logic svc_ok;

    assign run_set = ctrl[`GSW_CTRL_RUN];
    assign cnt_zero = (ctrl[15:`GSW_CTRL_CNT_LO] == 8'h00); // [RULE_11]
    assign any_fault = fault_in.wdog | fault_in.syntax | fault_in.alloc;
    assign blocked = block_sync.mem_locked | block_sync.link_fail | block_sync.prog_protect; // [RULE_08]

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic [2:0] w1c;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign w1c = (wr_go && aw_addr == `GSW_OFS_IRQ_STAT && w_strb[0]) ? w_data[2:0] : 3'h0;

    // capture address and data in either order
    always_ff @(posedge core_clk) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GSW_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
                `GSW_OFS_STATUS, `GSW_OFS_CTRL, `GSW_OFS_IRQ_STAT, `GSW_OFS_IRQ_MASK: begin
                    s_axi_bresp <= `GSW_RESP_OKAY;
                end
                default: begin
                    s_axi_bresp <= `GSW_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control and mask writes, byte lanes honoured
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl <= `GSW_RST_CTRL;
            irq_mask <= `GSW_RST_MASK;
        end else if (wr_go) begin
            if (aw_addr == `GSW_OFS_CTRL) begin
                if (w_strb[0]) begin
                    ctrl[7:0] <= w_data[7:0];
                end
                if (w_strb[1]) begin
                    ctrl[15:8] <= w_data[15:8];
                end
            end
            if (aw_addr == `GSW_OFS_IRQ_MASK && w_strb[0]) begin
                irq_mask <= w_data[2:0];
            end
        end
    end

    // read channel, data registered
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `GSW_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `GSW_RESP_OKAY;
            case (s_axi_araddr)
                `GSW_OFS_STATUS: s_axi_rdata <= {16'h0000, status};
                `GSW_OFS_CTRL: s_axi_rdata <= {16'h0000, ctrl};
                `GSW_OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat};
                `GSW_OFS_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `GSW_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // fault capture
    // ----------------------------------------
    // first fault kept, later ones ignored until reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fault_code <= `GSW_CODE_NONE;
            fatal <= 1'b0;
        end else if (fault_code == `GSW_CODE_NONE && any_fault) begin
            if (fault_in.wdog) begin
                fault_code <= `GSW_CODE_WDOG; // [RULE_10]
                fatal <= 1'b1;
            end else if (fault_in.alloc) begin
                fault_code <= `GSW_CODE_ALLOC; // [RULE_10]
                fatal <= 1'b1;
            end else begin
                fault_code <= `GSW_CODE_SYNTAX; // [RULE_10]
                fatal <= 1'b0;
            end
        end
    end

    // unreportable condition latches until reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            unreportable <= 1'b0;
        end else if (blocked) begin
            unreportable <= 1'b1; // [RULE_08]
        end
    end

    // ----------------------------------------
    // operating mode
    // ----------------------------------------
    always_comb begin
        next_mode = mode;
        case (mode)
            GSW_IDLE: begin
                if (run_set && !cnt_zero) begin
                    next_mode = GSW_RUN; // [RULE_11]
                end
            end
            GSW_RUN: begin
                if (!run_set || cnt_zero) begin
                    next_mode = GSW_IDLE;
                end
            end
            GSW_HALT: next_mode = GSW_HALT;
            default: next_mode = GSW_IDLE;
        endcase
        if (fault_code != `GSW_CODE_NONE || any_fault || unreportable || blocked) begin
            next_mode = GSW_HALT; // [RULE_01] [RULE_09]
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode <= GSW_IDLE;
        end else begin
            mode <= next_mode;
        end
    end

    assign comm_enable = (mode == GSW_RUN); // [RULE_09]
    assign err_led = (mode == GSW_HALT); // [RULE_09]

    // ----------------------------------------
    // last serviced unit
    // ----------------------------------------
    function automatic logic [7:0] to_bcd(input logic [4:0] u);
        logic [3:0] tens;
        logic [4:0] ones;
        tens = (u >= 5'd30) ? 4'h3 : (u >= 5'd20) ? 4'h2 : (u >= 5'd10) ? 4'h1 : 4'h0;
        ones = u - (5'(tens) * 5'd10); // product kept at 5 bits so 30 does not wrap
        return {tens, ones[3:0]};
    endfunction

    assign svc_ok = svc_in.done && (mode == GSW_RUN);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            last_unit <= `GSW_UNIT_NONE; // [RULE_04]
        end else if (svc_ok) begin
            last_unit <= svc_in.absent ? `GSW_UNIT_NONE : to_bcd(svc_in.unit); // [RULE_03] [RULE_05]
        end
    end

    // ----------------------------------------
    // status word composition
    // ----------------------------------------
    always_comb begin
        if (fault_code != `GSW_CODE_NONE) begin
            next_status[15:12] = fatal ? `GSW_FATAL_DIGIT : `GSW_OK_DIGIT; // [RULE_02] [RULE_07]
            next_status[11:8] = `GSW_STOP_DIGIT; // [RULE_01]
            next_status[7:0] = fault_code; // [RULE_10]
        end else begin
            next_status[15:12] = `GSW_OK_DIGIT; // [RULE_07]
            next_status[11:8] = (mode == GSW_RUN) ? `GSW_RUN_DIGIT : `GSW_STOP_DIGIT; // [RULE_06]
            next_status[7:0] = (cnt_zero || !run_set) ? `GSW_UNIT_NONE : last_unit; // [RULE_05]
        end
    end

    // one whole-word update per change, frozen when the cpu cannot take it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            status <= `GSW_RST_STATUS;
            host_word_memory_data <= `GSW_RST_STATUS;
            host_word_memory_write <= 1'b0;
        end else begin
            host_word_memory_write <= 1'b0;
            if (!unreportable && !blocked && next_status != status) begin
                status <= next_status; // [RULE_12]
                host_word_memory_data <= next_status; // [RULE_12]
                host_word_memory_write <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    // bit0 serviced, bit1 fault, bit2 unreportable; set wins over clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_stat <= 3'h0;
        end else begin
            irq_stat <= (irq_stat & ~w1c) | {blocked, any_fault, svc_ok};
        end
    end

    assign irq = |(irq_stat & irq_mask);
endmodule // gsw_status
`default_nettype wire

// ==== rtl/gsw_cfg.svh ====
// constants of the gateway status word block
`ifndef GSW_CFG_SVH
`define GSW_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define GSW_OFS_STATUS 12'h000
`define GSW_OFS_CTRL 12'h004
`define GSW_OFS_IRQ_STAT 12'h008
`define GSW_OFS_IRQ_MASK 12'h00c
// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define GSW_CTRL_RUN 0
`define GSW_CTRL_CNT_LO 8
`define GSW_FATAL_DIGIT 4'h8
`define GSW_OK_DIGIT 4'h0
`define GSW_RUN_DIGIT 4'h1
`define GSW_STOP_DIGIT 4'h0
`define GSW_CODE_WDOG 8'h01
`define GSW_CODE_SYNTAX 8'h02
`define GSW_CODE_ALLOC 8'h15
`define GSW_CODE_NONE 8'h00
`define GSW_UNIT_NONE 8'h00
// ----------------------------------------
// reset values
// ----------------------------------------
`define GSW_RST_CTRL 16'h0000
`define GSW_RST_MASK 3'h0
`define GSW_RST_STATUS 16'h0000
// ----------------------------------------
// axi responses
// ----------------------------------------
`define GSW_RESP_OKAY 2'h0
`define GSW_RESP_SLVERR 2'h2
`endif

// ==== rtl/gsw_pkg.sv ====
// types of the gateway status word block
`default_nettype none
package gsw_pkg;
    // fault events from the gateway core, one-cycle pulses
    typedef struct packed {
        logic wdog;
        logic syntax;
        logic alloc;
    } gsw_fault_t;
    // conditions under which the cpu cannot be told of a fault
    typedef struct packed {
        logic mem_locked;
        logic link_fail;
        logic prog_protect;
    } gsw_block_t;
    // one serviced component report
    typedef struct packed {
        logic done;
        logic absent;
        logic [4:0] unit;
    } gsw_svc_t;
    // gateway operating mode, gray along idle-run-halt
    typedef enum logic [1:0] {
        GSW_IDLE = 2'b00,
        GSW_RUN = 2'b01,
        GSW_HALT = 2'b11
    } gsw_mode_t;
endpackage
`default_nettype wire

// ==== tb/gsw_host_mem.sv ====
// host memory model that keeps the status word
`default_nettype none
module gsw_host_mem (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // status word updates
    input wire logic [15:0] host_word_memory_data,
    input wire logic host_word_memory_write,
    // host conditions asked by the bench
    input wire logic [2:0] cond_req,
    output var gsw_pkg::gsw_block_t block_pin,
    // stored copy
    output logic [15:0] mem_word,
    output logic [7:0] wcnt
);
    timeunit 1ns;
    timeprecision 1ps;
    import gsw_pkg::*;
    // store each update whole and count it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mem_word <= 16'h0000;
            wcnt <= 8'h00;
        end else if (host_word_memory_write) begin
            mem_word <= host_word_memory_data;
            wcnt <= wcnt + 8'h01;
        end
    end
    // locked memory, failed link, protected program
    assign block_pin = cond_req;
endmodule // gsw_host_mem
`default_nettype wire

// ==== tb/gsw_status_chk.sv ====
// assertions on the status word block ports
`default_nettype none
module gsw_status_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // watched ports
    input wire gsw_pkg::gsw_fault_t fault_in,
    input wire gsw_pkg::gsw_block_t block_pin,
    input wire logic [15:0] host_word_memory_data,
    input wire logic host_word_memory_write,
    input wire logic comm_enable,
    input wire logic err_led
);
    timeunit 1ns;
    timeprecision 1ps;
    import gsw_pkg::*;
    logic [15:0] w;
    // short name of the word
    assign w = host_word_memory_data;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // ----
    // word layout and timing
    // ----
    init_zero_a: assert property ($fell(reset) |-> w == 16'h0000)
        else $error("word not clear");
    fatal_word_a: assert property (w[15] |-> w[15:8] == 8'h80 && w[7:0] inside {8'h01, 8'h15})
        else $error("fatal layout bad");
    clear_word_a: assert property (!w[15] |-> w[15:12] == 4'h0 && w[7:0] <= 8'h31 && w[3:0] <= 4'h9)
        else $error("no error layout bad");
    run_digit_a: assert property (comm_enable [*6] |-> w[11:8] == 4'h1)
        else $error("run digit not set");
    halt_a: assert property (|fault_in |=> err_led && !comm_enable)
        else $error("no halt on fault");
    wdog_word_a: assert property (fault_in.wdog && !err_led |-> ##[1:4] host_word_memory_write && w == 16'h8001)
        else $error("watchdog word missing");
    block_halt_a: assert property ((|block_pin) [*5] |-> err_led && !comm_enable)
        else $error("no halt on block");
    frozen_a: assert property ((|block_pin) [*8] |-> !host_word_memory_write)
        else $error("write while blocked");
    one_write_a: assert property (w != $past(w) |-> host_word_memory_write)
        else $error("word changed without write");
endmodule // gsw_status_chk
`default_nettype wire

// ==== tb/gsw_status_tb_top.sv ====
// self-checking bench of the status word block
`include "gsw_cfg.svh"
`default_nettype none
module gsw_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import gsw_pkg::*;
    localparam logic [1:0] ok = `GSW_RESP_OKAY;
    localparam logic [11:0] ctrl_a = `GSW_OFS_CTRL;
    localparam logic [11:0] stat_a = `GSW_OFS_IRQ_STAT;
    logic core_clk, reset, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, hw_wr, comm_enable, err_led, irq;
    logic [11:0] awa, ara;
    logic [31:0] wd, rd, rv_d;
    logic [1:0] bresp, rresp;
    logic [2:0] cond_req;
    logic [7:0] wcnt, wc;
    logic [15:0] hw_data, mem_word;
    gsw_fault_t fault_in;
    gsw_svc_t svc_in;
    gsw_block_t block_pin;
    int bad_count, samples_checked;
    // rows: address, write data, read back, response
    logic [77:0] rows [5] = '{{`GSW_OFS_STATUS, 32'hffff, 32'h0, ok}, {stat_a, 32'h7, 32'h0, ok},
        {`GSW_OFS_IRQ_MASK, 32'h7, 32'h7, ok}, {ctrl_a, 32'h3200, 32'h3200, ok}, {12'h010, 32'h5, 32'h0, 2'h2}};
    logic [5:0] units [5] = '{6'h05, 6'h1f, 6'h27, 6'h13, 6'h00};
    logic [15:0] uexp [5] = '{16'h0105, 16'h0131, 16'h0100, 16'h0119, 16'h0100};
    logic [2:0] flt [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
    logic [15:0] fexp [4] = '{16'h8015, 16'h0002, 16'h8001, 16'h8001};
    gsw_status u_gsw_status (.core_clk(core_clk), .reset(reset),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .fault_in(fault_in), .svc_in(svc_in), .block_pin(block_pin),
        .host_word_memory_data(hw_data), .host_word_memory_write(hw_wr), .comm_enable(comm_enable),
        .err_led(err_led), .irq(irq));
    gsw_host_mem u_gsw_host_mem (.core_clk(core_clk), .reset(reset), .host_word_memory_data(hw_data),
        .host_word_memory_write(hw_wr), .cond_req(cond_req), .block_pin(block_pin), .mem_word(mem_word),
        .wcnt(wcnt));
    // 250 MHz clock
    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic guard(input int n);
        if (n > 40) begin
            chk("wait bound", 48'h0, 48'h1);
            summarize();
        end
    endtask
    // one write, address and data offered together
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] s);
        int n;
        n = 0;
        awa <= a;
        wd <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        do begin
            tick(1);
            if (awv && awr) awv <= 1'h0;
            if (wv && wr) wv <= 1'h0;
            if (br && bv) begin
                br <= 1'h0;
                chk("bresp", bresp, s);
            end
            n++;
            guard(n);
        end while (awv || wv || br);
    endtask
    // one read, data kept in rv_d
    task automatic axi_rd(input logic [11:0] a, input logic [1:0] s);
        int n;
        n = 0;
        ara <= a;
        arv <= 1'h1;
        rr <= 1'h1;
        do begin
            tick(1);
            if (arv && arr) arv <= 1'h0;
            if (rr && rv) begin
                rr <= 1'h0;
                rv_d = rd;
                chk("rresp", rresp, s);
            end
            n++;
            guard(n);
        end while (arv || rr);
    endtask
    task automatic do_reset();
        reset <= 1'h1;
        tick(16);
        reset <= 1'h0;
        tick(1);
    endtask
    task automatic wait_word(input logic [15:0] e);
        int n;
        n = 0;
        while (mem_word !== e) begin
            tick(1);
            n++;
            guard(n);
        end
        chk("status word", mem_word, e);
    endtask
    task automatic pulse(input logic [2:0] f, input logic [6:0] v);
        fault_in <= f;
        svc_in <= v;
        tick(1);
        fault_in <= '0;
        svc_in <= '0;
        tick(1);
    endtask
    task automatic go();
        do_reset();
        axi_wr(ctrl_a, 32'h3201, ok);
        wait_word(16'h0100);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        logic [11:0] a;
        logic [31:0] d, r;
        logic [1:0] s;
        {reset, awv, wv, br, arv, rr} = 6'h20;
        {awa, ara, wd, cond_req} = '0;
        fault_in = '0;
        svc_in = '0;
        bad_count = 0;
        samples_checked = 0;
        do_reset();
        chk("idle outputs", {hw_data, comm_enable, err_led, irq}, 48'h0);
        foreach (rows[i]) begin
            {a, d, r, s} = rows[i];
            axi_rd(a, s);
            chk("reset value", rv_d, 48'h0);
            axi_wr(a, d, s);
            axi_rd(a, s);
            chk("read back", rv_d, r);
        end
        axi_wr(ctrl_a, 32'h1, ok);
        pulse(3'h0, 7'h45);
        tick(6);
        chk("count zero", {mem_word, comm_enable}, 48'h0);
        axi_wr(ctrl_a, 32'h3201, ok);
        wait_word(16'h0100);
        foreach (units[i]) begin
            pulse(3'h0, {1'h1, units[i]});
            wait_word(uexp[i]);
        end
        chk("irq raised", irq, 48'h1);
        axi_wr(`GSW_OFS_IRQ_MASK, 32'h0, ok);
        chk("irq masked", irq, 48'h0);
        axi_wr(`GSW_OFS_IRQ_MASK, 32'h7, ok);
        axi_wr(stat_a, 32'h1, ok);
        axi_rd(stat_a, ok);
        chk("irq cleared", {irq, rv_d}, 48'h0);
        axi_wr(ctrl_a, 32'h3200, ok);
        wait_word(16'h0000);
        foreach (flt[i]) begin
            go();
            pulse(flt[i], 7'h0);
            wait_word(fexp[i]);
            chk("halted", {comm_enable, err_led}, 48'h1);
            axi_rd(stat_a, ok);
            chk("fault event", rv_d[1], 48'h1);
            pulse(3'h4, 7'h0);
            tick(6);
            chk("first fault kept", mem_word, fexp[i]);
        end
        for (int i = 0; i < 3; i++) begin
            go();
            cond_req <= 3'h1 << i;
            tick(8);
            chk("unreportable", {comm_enable, err_led}, 48'h1);
            wc = wcnt;
            pulse(3'h4, 7'h0);
            tick(6);
            chk("word frozen", {mem_word, wcnt}, {16'h0100, wc});
            axi_rd(stat_a, ok);
            chk("block event", rv_d[2], 48'h1);
            cond_req <= 3'h0;
        end
        summarize();
    end
endmodule // gsw_status_tb_top
bind gsw_status gsw_status_chk u_gsw_status_chk (.core_clk(core_clk), .reset(reset), .fault_in(fault_in),
    .block_pin(block_pin), .host_word_memory_data(host_word_memory_data),
    .host_word_memory_write(host_word_memory_write), .comm_enable(comm_enable), .err_led(err_led));
`default_nettype wire
